// File: rtl/ahwp_pkg.sv
// Constants shared by the asynchronous host write port
package ahwp_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned HALF_W      = 16;
  localparam int unsigned ADDR_W      = 7;   // Address bits A[7:1]
  localparam int unsigned WSEL_W      = 2;   // Word select A[2:1]
  localparam int unsigned REGIDX_W    = ADDR_W;
  localparam int unsigned CFG_W       = 8;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CFG_SETUP_NS  = 200;
  localparam int unsigned CFG_HOLD_NS   = 10;
  // Hold rounds up to whole cycles, least one cycle
  localparam int unsigned CFG_HOLD_CYC =
    (CFG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [CFG_W-1:0]  CFG_RST  = 8'h00;
endpackage

// File: rtl/ahwp_fifo.sv
// Synchronous valid/ready FIFO for the transmit data path
`timescale 1ns/1ps
`default_nettype none
module ahwp_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  // Honest full and empty straight from the occupancy count
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count next values
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
    end
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Register pointers; storage has no reset, only written on push
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: rtl/ahwp_port.sv
// Host write port: strobe-framed writes to registers or transmit FIFO
// Behaviour
// - 16/32-bit writes alike; upper half ignored when 16
// - Cycle starts when select and strobe both low
// - Cycle ends when either line rises
// - FIFO select high routes write to FIFO
// - FIFO mode keeps A[2:1], ignores A[7:3]
// - FIFO select timed like an address line
// - Configuration inputs captured at reset release
`timescale 1ns/1ps
`default_nettype none
module ahwp_port #(
  parameter int unsigned DATA_W     = ahwp_pkg::DATA_W,
  parameter int unsigned FIFO_DEPTH = ahwp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  // Host bus
  input  wire logic                        host_select_n,
  input  wire logic                        host_write_strobe_n,
  input  wire logic                        fifo_direct_sel,
  input  wire logic [ahwp_pkg::ADDR_W-1:0] host_addr,
  input  wire logic [DATA_W-1:0]           host_data,
  input  wire logic                        bus_is_16bit,
  // Reset line and configuration straps
  input  wire logic                        device_reset_n,
  input  wire logic [ahwp_pkg::CFG_W-1:0]  cfg_straps,
  // Register write output
  output logic                             reg_wr_pulse,
  output logic [ahwp_pkg::ADDR_W-1:0]      reg_wr_index,
  output logic [DATA_W-1:0]                reg_wr_data,
  // Transmit FIFO drain side
  output logic                             tx_valid,
  input  wire logic                        tx_ready,
  output logic [DATA_W-1:0]                tx_data,
  output logic [ahwp_pkg::WSEL_W-1:0]      tx_word_sel,
  output logic                             tx_fifo_ready,
  // Captured configuration and dropped-write flag
  output logic [ahwp_pkg::CFG_W-1:0]       cfg_latched,
  output logic                             write_dropped
);
  localparam int unsigned FW = DATA_W + ahwp_pkg::WSEL_W;

  // Mask upper half for 16-bit bus
  function automatic logic [DATA_W-1:0] lane_mask(input logic [DATA_W-1:0] d,
                                                  input logic narrow);
    lane_mask = narrow ? {{(DATA_W-ahwp_pkg::HALF_W){1'b0}}, d[ahwp_pkg::HALF_W-1:0]} : d;
  endfunction

  logic                          in_cycle;
  logic                          next_in_cycle;
  logic                          hold_fifo;
  logic                          next_hold_fifo;
  logic [ahwp_pkg::ADDR_W-1:0]   hold_addr;
  logic [ahwp_pkg::ADDR_W-1:0]   next_hold_addr;
  logic [DATA_W-1:0]             hold_data;
  logic [DATA_W-1:0]             next_hold_data;
  logic                          next_reg_wr_pulse;
  logic [ahwp_pkg::ADDR_W-1:0]   next_reg_wr_index;
  logic [DATA_W-1:0]             next_reg_wr_data;
  logic                          next_write_dropped;
  logic                          push_valid;
  logic                          push_ready;
  logic                          next_push_valid;
  logic [FW-1:0]                 push_word;
  logic [FW-1:0]                 next_push_word;
  logic                          active;
  logic                          ending;
  logic                          f_valid;
  logic [FW-1:0]                 f_data;

  assign active = !host_select_n && !host_write_strobe_n;
  assign ending = in_cycle && !active;

  // Cycle tracker; sampled values hold the last in-cycle state
  always_comb begin
    next_in_cycle      = active;
    next_hold_fifo     = hold_fifo;
    next_hold_addr     = hold_addr;
    next_hold_data     = hold_data;
    next_reg_wr_pulse  = 1'b0;
    next_reg_wr_index  = reg_wr_index;
    next_reg_wr_data   = reg_wr_data;
    next_write_dropped = 1'b0;
    next_push_valid    = push_valid && !push_ready;
    next_push_word     = push_word;
    if (active) begin
      // Track while active so commit sees values before the ending edge
      next_hold_fifo = fifo_direct_sel;
      next_hold_addr = host_addr;
      next_hold_data = lane_mask(host_data, bus_is_16bit);
    end
    if (ending) begin
      if (hold_fifo) begin
        // Upper address skipped, only word select kept
        if (next_push_valid) begin
          next_write_dropped = 1'b1;
        end else begin
          next_push_valid = 1'b1;
          next_push_word  = {hold_addr[ahwp_pkg::WSEL_W-1:0], hold_data};
        end
      end else begin
        next_reg_wr_pulse = 1'b1;
        next_reg_wr_index = hold_addr;
        next_reg_wr_data  = hold_data;
      end
    end
  end

  // Register cycle state and outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_cycle      <= 1'b0;
      hold_fifo     <= 1'b0;
      hold_addr     <= '0;
      hold_data     <= ahwp_pkg::DATA_RST;
      reg_wr_pulse  <= 1'b0;
      reg_wr_index  <= '0;
      reg_wr_data   <= ahwp_pkg::DATA_RST;
      write_dropped <= 1'b0;
      push_valid    <= 1'b0;
      push_word     <= '0;
    end else begin
      in_cycle      <= next_in_cycle;
      hold_fifo     <= next_hold_fifo;
      hold_addr     <= next_hold_addr;
      hold_data     <= next_hold_data;
      reg_wr_pulse  <= next_reg_wr_pulse;
      reg_wr_index  <= next_reg_wr_index;
      reg_wr_data   <= next_reg_wr_data;
      write_dropped <= next_write_dropped;
      push_valid    <= next_push_valid;
      push_word     <= next_push_word;
    end
  end

  // Transmit FIFO; full stalls the push stage and is flagged to the host side
  ahwp_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (f_valid),
    .out_ready (tx_ready || !tx_valid),
    .out_data  (f_data)
  );

  // Output stage so drain outputs come from flops
  logic                        next_tx_valid;
  logic [DATA_W-1:0]           next_tx_data;
  logic [ahwp_pkg::WSEL_W-1:0] next_tx_word_sel;
  always_comb begin
    next_tx_valid    = tx_valid;
    next_tx_data     = tx_data;
    next_tx_word_sel = tx_word_sel;
    if (tx_ready || !tx_valid) begin
      next_tx_valid    = f_valid;
      next_tx_data     = f_data[DATA_W-1:0];
      next_tx_word_sel = f_data[FW-1:DATA_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_valid      <= 1'b0;
      tx_data       <= ahwp_pkg::DATA_RST;
      tx_word_sel   <= '0;
      tx_fifo_ready <= 1'b1;
    end else begin
      tx_valid      <= next_tx_valid;
      tx_data       <= next_tx_data;
      tx_word_sel   <= next_tx_word_sel;
      tx_fifo_ready <= push_ready;
    end
  end

  // Strap capture: straps taken at the first edge that samples the reset line high
  logic                       rst_prev;
  logic [ahwp_pkg::CFG_W-1:0] next_cfg_latched;
  always_comb begin
    next_cfg_latched = cfg_latched;
    if (device_reset_n && !rst_prev) begin
      next_cfg_latched = cfg_straps;
    end
  end

  // Latch straps on the sampled rising edge of the reset line
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rst_prev    <= 1'b0;
      cfg_latched <= ahwp_pkg::CFG_RST;
    end else begin
      rst_prev    <= device_reset_n;
      cfg_latched <= next_cfg_latched;
    end
  end

  a_reg_commit: assert property (@(posedge sys_clk) disable iff (srst)
    (in_cycle && !active && !hold_fifo) |=> reg_wr_pulse
      && reg_wr_index == $past(hold_addr))
    else $error("register write not committed at cycle end");
  a_no_early: assert property (@(posedge sys_clk) disable iff (srst)
    (host_select_n || host_write_strobe_n) |=> !in_cycle)
    else $error("cycle started without both lines low");
  a_fifo_route: assert property (@(posedge sys_clk) disable iff (srst)
    (ending && hold_fifo) |=> !reg_wr_pulse && (push_valid || write_dropped))
    else $error("fifo write not routed to fifo");
  a_half_mask: assert property (@(posedge sys_clk) disable iff (srst)
    (active && bus_is_16bit) |=> hold_data[DATA_W-1:ahwp_pkg::HALF_W] == '0)
    else $error("upper half kept on 16-bit write");
  a_word_sel: assert property (@(posedge sys_clk) disable iff (srst)
    (ending && hold_fifo && !push_valid) |=>
      push_word[FW-1:DATA_W] == $past(hold_addr[ahwp_pkg::WSEL_W-1:0]))
    else $error("word select lost in fifo mode");
  a_cfg_capture: assert property (@(posedge sys_clk) disable iff (srst)
    (device_reset_n && !rst_prev) |=> cfg_latched == $past(cfg_straps))
    else $error("straps not captured at reset rise");
  a_single_pulse: assert property (@(posedge sys_clk) disable iff (srst)
    reg_wr_pulse |=> !reg_wr_pulse)
    else $error("one cycle produced two commits");
  a_fifo_sel_hold: assert property (@(posedge sys_clk) disable iff (srst)
    active |=> hold_fifo == $past(fifo_direct_sel))
    else $error("fifo select not sampled like address");
endmodule
`default_nettype wire

// File: tb/ahwp_host.sv
// Host bus master model driving strobe-framed writes and reset straps
`timescale 1ns/1ps
`default_nettype none
module ahwp_host (
  // Clock
  input  wire logic                       sys_clk,
  // Host bus
  output logic                            sel_n,
  output logic                            wr_n,
  output logic                            fsel,
  output logic [ahwp_pkg::ADDR_W-1:0]     addr,
  output logic [ahwp_pkg::DATA_W-1:0]     data,
  // Reset line and straps
  output logic                            rst_n,
  output logic [ahwp_pkg::CFG_W-1:0]      straps
);
  initial begin
    sel_n  = 1'b1;
    wr_n   = 1'b1;
    fsel   = 1'b0;
    addr   = 7'h00;
    data   = 32'h0000_0000;
    rst_n  = 1'b1;
    straps = 8'h5A;
  end

  // One write; ord picks which line falls and which rises first
  task automatic write(input logic f, input logic [6:0] a, input logic [31:0] d,
                       input int unsigned ord, input int unsigned len);
    @(negedge sys_clk);
    fsel = f;
    addr = a;
    data = d;
    if (ord[0]) sel_n = 1'b0;
    else wr_n = 1'b0;
    @(negedge sys_clk);
    sel_n = 1'b0;
    wr_n  = 1'b0;
    // At least one sampling edge with both lines low, even for len of zero
    repeat (len + 1) @(negedge sys_clk);
    if (ord[1]) sel_n = 1'b1;
    else wr_n = 1'b1;
    @(negedge sys_clk);
    // Released bus shows inverse so stale values never look valid
    sel_n = 1'b1;
    wr_n  = 1'b1;
    fsel  = ~f;
    addr  = ~a;
    data  = ~d;
  endtask

  // Strobe low while deselected, which must not start a cycle
  task automatic strobe_only();
    @(negedge sys_clk);
    wr_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    wr_n = 1'b1;
  endtask

  // Straps held 205 ns before and 15 ns past the reset rise
  task automatic pulse_reset(input logic [7:0] s);
    @(negedge sys_clk);
    rst_n  = 1'b0;
    straps = s;
    repeat (41) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    straps = ~s;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the host write port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk, srst, w16, tx_ready, stall;
  logic        sel_n, wr_n, fsel, rst_n;
  logic [6:0]  addr, reg_wr_index;
  logic [31:0] data, reg_wr_data, tx_data;
  logic [7:0]  straps, cfg_latched;
  logic [1:0]  tx_word_sel;
  logic        reg_wr_pulse, tx_valid, tx_fifo_ready, write_dropped;
  logic [38:0] reg_q[$];
  logic [33:0] tx_q[$];
  int          n_fail, compares, cyc, n_drop;
  logic [31:0] d, seed_dummy;
  logic [6:0]  a;

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ahwp_host host (.sys_clk(sys_clk), .sel_n(sel_n), .wr_n(wr_n), .fsel(fsel), .addr(addr),
                  .data(data), .rst_n(rst_n), .straps(straps));

  ahwp_port dut (.sys_clk(sys_clk), .srst(srst), .host_select_n(sel_n),
    .host_write_strobe_n(wr_n), .fifo_direct_sel(fsel), .host_addr(addr), .host_data(data),
    .bus_is_16bit(w16), .device_reset_n(rst_n), .cfg_straps(straps),
    .reg_wr_pulse(reg_wr_pulse), .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_word_sel(tx_word_sel),
    .tx_fifo_ready(tx_fifo_ready), .cfg_latched(cfg_latched), .write_dropped(write_dropped));

  // Upper half cleared on a narrow bus
  function automatic logic [31:0] exp_data(input logic [31:0] v, input logic n);
    return n ? {16'h0000, v[15:0]} : v;
  endfunction

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Monitors look at the falling edge, where registered outputs are settled
  always @(negedge sys_clk) begin
    logic r;
    r = stall ? 1'b0 : 1'($urandom % 2);
    if (reg_wr_pulse === 1'b1) begin
      chk(reg_q.size() > 0, "unexpected register write");
      if (reg_q.size() > 0) chk({reg_wr_index, reg_wr_data} === reg_q.pop_front(), "reg");
    end
    if (write_dropped === 1'b1) begin
      n_drop++;
      void'(tx_q.pop_back());
    end
    if (tx_valid === 1'b1 && r) begin
      chk(tx_q.size() > 0, "unexpected fifo word");
      if (tx_q.size() > 0) chk({tx_word_sel, tx_data} === tx_q.pop_front(), "fifo");
    end
    tx_ready <= r;
  end

  // Hang guard, well beyond the expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic f, input int unsigned i);
    d = $urandom;
    a = 7'($urandom);
    w16 = 1'($urandom % 2);
    // Queue after the edge so a drop of the previous write pops its own entry
    @(posedge sys_clk);
    if (f) tx_q.push_back({a[1:0], exp_data(d, w16)});
    else reg_q.push_back({a, exp_data(d, w16)});
    host.write(f, a, d, i % 4, i % 3);
  endtask

  initial begin
    srst = 1'b1;
    w16 = 1'b0;
    tx_ready = 1'b0;
    stall = 1'b0;
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    seed_dummy = $urandom(32'h7C5B);
    repeat (3) @(negedge sys_clk);
    chk(cfg_latched === 8'h5A && tx_fifo_ready === 1'b1, "reset state");
    for (int i = 0; i < 12; i++) wr(1'b0, i);
    host.strobe_only();
    repeat (6) @(negedge sys_clk);
    chk(reg_q.size() == 0, "register writes missing");
    $display("test registers done");
    for (int i = 0; i < 8; i++) wr(1'b1, i);
    repeat (40) @(negedge sys_clk);
    chk(tx_q.size() == 0, "fifo words missing");
    $display("test fifo direct done");
    stall = 1'b1;
    for (int i = 0; i < 14; i++) wr(1'b1, i);
    repeat (4) @(negedge sys_clk);
    // Capacity is the output register, the FIFO and the push stage
    chk(n_drop + ahwp_pkg::FIFO_DEPTH + 2 == 14 && tx_fifo_ready === 1'b0, "full fifo not refused");
    stall = 1'b0;
    repeat (80) @(negedge sys_clk);
    chk(tx_q.size() == 0 && tx_valid === 1'b0, "fifo not drained");
    $display("test fill and drain done");
    host.pulse_reset(8'hC3);
    repeat (5) @(negedge sys_clk);
    chk(cfg_latched === 8'hC3, "straps not captured at reset rise");
    $display("test straps done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
